// ==== rtc_chk_sva.sv ====
`timescale 1ns/1ps
// port-level checks on the bus answer and the event outputs
module rtc_chk_sva
(
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // apb side
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  // events
  input wire irq_out,
  input wire wake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // unmapped: beyond the mask register or not word aligned
  wire bad_a = (paddr_in > 8'h18) || (paddr_in[1:0] != 2'h0);
  // completed write to status or mask, the only ways to drop the interrupt
  wire clr_w = psel_in && penable_in && pready_out && pwrite_in && (paddr_in == 8'h14 || paddr_in == 8'h18);
  a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready held too long");
  a_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("answer late");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in)) else $error("ready unasked");
  a_err_map: assert property (pready_out |-> pslverr_out == bad_a) else $error("error flag wrong");
  a_err_alone: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  a_err_rdata: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0) else $error("refused read data");
  a_wake_irq: assert property (wake_out |-> irq_out) else $error("wake without event");
  a_irq_sticky: assert property ($fell(irq_out) |-> $past(clr_w, 2) || $past(clr_w, 1))
    else $error("interrupt dropped on its own");
endmodule
bind rtc_core rtc_chk_sva u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .irq_out(irq_out), .wake_out(wake_out));

// ==== rtc_core.v ====
`timescale 1ns/1ps
`include "rtc_map.vh"
// real-time clock with alarms, stopwatch and tick interrupts behind apb
module rtc_core
#(
  parameter PRESCALE_DIV = 32768,
  parameter PRESCALE_W = 15,
  parameter SW_W = 16,
  parameter ADDR_W = 8
)
(
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // crystal clock, sampled as a pin
  input wire xtal_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // events
  output reg irq_out,
  output reg wake_out
);

  localparam [5:0] SEC_ONE = 6'h01;
  localparam [5:0] MIN_ONE = 6'h01;
  localparam [4:0] HOUR_ONE = 5'h01;
  localparam [14:0] DAY_ONE = 15'h0001;
  localparam [SW_W-1:0] SW_ONE = {{(SW_W-1){1'b0}}, 1'b1};

  // timekeeping state
  reg [5:0] sec_ff; // seconds 0..59
  reg [5:0] min_ff; // minutes 0..59
  reg [4:0] hour_ff; // hours 0..23
  reg [14:0] day_ff; // days, wraps silently
  reg [SW_W-1:0] sw_ff; // stopwatch count
  reg [31:0] alm_tod_ff; // time-of-day alarm setting
  reg [31:0] alm_day_ff; // day and time alarm setting
  reg [`RTC_CTRL_W-1:0] ctrl_ff; // control bits
  reg [`RTC_EV_W-1:0] stat_ff; // sticky event flags
  reg [`RTC_EV_W-1:0] mask_ff; // interrupt enables

  // next values
  reg [5:0] nxt_sec;
  reg [5:0] nxt_min;
  reg [4:0] nxt_hour;
  reg [14:0] nxt_day;
  reg [SW_W-1:0] nxt_sw;
  reg [`RTC_CTRL_W-1:0] nxt_ctrl;
  reg [`RTC_EV_W-1:0] nxt_stat;
  reg [`RTC_EV_W-1:0] ev_set; // events raised this cycle
  reg [`RTC_EV_W-1:0] ev_clr; // flags cleared by software

  // bus decode results
  reg [31:0] rd_mux;
  reg addr_ok;
  reg wr_time;
  reg wr_alm_tod;
  reg wr_alm_day;
  reg wr_sw;
  reg wr_ctrl;
  reg wr_stat;
  reg wr_mask;

  // crystal edge and one-second tick
  wire xtal_rise; // one-cycle pulse per crystal rising edge
  wire tick; // one-cycle pulse per second
  wire run; // timekeeping enabled

  // apb phases; the write takes effect on the edge where pready is seen high
  wire apb_acc = psel_in & penable_in & pready_out;
  wire apb_wr = apb_acc & pwrite_in & addr_ok;

  // packed current time for reads, and the next time for the alarm compares
  wire [31:0] time_word = {day_ff, hour_ff, min_ff, sec_ff};
  wire [31:0] nxt_word;

  assign run = ctrl_ff[`RTC_CTRL_RUN];

  // crystal passes three flops before its edges count
  rtc_sync u_sync
  (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(xtal_in),
    .rise_out(xtal_rise)
  );

  // a time write restarts the partial second so the new time starts clean
  rtc_prescale
  #(
    .PRESCALE_DIV(PRESCALE_DIV),
    .CNT_W(PRESCALE_W)
  )
  u_prescale
  (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .edge_in(xtal_rise & run),
    .clear_in(wr_time & apb_wr),
    .tick_out(tick)
  );

  // address decode, read data mux and write strobes
  always @*
  begin
    rd_mux = 32'h00000000;
    addr_ok = 1'b1;
    wr_time = 1'b0;
    wr_alm_tod = 1'b0;
    wr_alm_day = 1'b0;
    wr_sw = 1'b0;
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (paddr_in == `RTC_OFS_TIME)
    begin
      rd_mux = time_word;
      wr_time = 1'b1;
    end
    else if (paddr_in == `RTC_OFS_ALM_TOD)
    begin
      rd_mux = alm_tod_ff;
      wr_alm_tod = 1'b1;
    end
    else if (paddr_in == `RTC_OFS_ALM_DAY)
    begin
      rd_mux = alm_day_ff;
      wr_alm_day = 1'b1;
    end
    else if (paddr_in == `RTC_OFS_SWATCH)
    begin
      rd_mux[SW_W-1:0] = sw_ff;
      wr_sw = 1'b1;
    end
    else if (paddr_in == `RTC_OFS_CTRL)
    begin
      rd_mux[`RTC_CTRL_W-1:0] = ctrl_ff;
      wr_ctrl = 1'b1;
    end
    else if (paddr_in == `RTC_OFS_STAT)
    begin
      rd_mux[`RTC_EV_W-1:0] = stat_ff;
      wr_stat = 1'b1;
    end
    else if (paddr_in == `RTC_OFS_MASK)
    begin
      rd_mux[`RTC_EV_W-1:0] = mask_ff;
      wr_mask = 1'b1;
    end
    else
    begin
      // unmapped: reads zero and answers with an error
      addr_ok = 1'b0;
    end
  end

  // cascaded counters; a software write to the time register wins over a tick
  always @*
  begin
    nxt_sec = sec_ff;
    nxt_min = min_ff;
    nxt_hour = hour_ff;
    nxt_day = day_ff;
    ev_set = {`RTC_EV_W{1'b0}};
    if (apb_wr & wr_time)
    begin
      nxt_sec = pwdata_in[`RTC_SEC_MSB:`RTC_SEC_LSB];
      nxt_min = pwdata_in[`RTC_MIN_MSB:`RTC_MIN_LSB];
      nxt_hour = pwdata_in[`RTC_HOUR_MSB:`RTC_HOUR_LSB];
      nxt_day = pwdata_in[`RTC_DAY_MSB:`RTC_DAY_LSB];
    end
    else if (tick)
    begin
      ev_set[`RTC_EV_SEC] = 1'b1;
      if (sec_ff == `RTC_SEC_LAST)
      begin
        nxt_sec = 6'h00;
        ev_set[`RTC_EV_MIN] = 1'b1;
        if (min_ff == `RTC_MIN_LAST)
        begin
          nxt_min = 6'h00;
          ev_set[`RTC_EV_HOUR] = 1'b1;
          if (hour_ff == `RTC_HOUR_LAST)
          begin
            nxt_hour = 5'h00;
            ev_set[`RTC_EV_DAY] = 1'b1;
            nxt_day = day_ff + DAY_ONE;
          end
          else
          begin
            nxt_hour = hour_ff + HOUR_ONE;
          end
        end
        else
        begin
          nxt_min = min_ff + MIN_ONE;
        end
      end
      else
      begin
        nxt_sec = sec_ff + SEC_ONE;
      end
    end
    // alarms compare the time the counters move to on this tick
    if (tick & ~(apb_wr & wr_time))
    begin
      if (ctrl_ff[`RTC_CTRL_ALM_TOD_EN] &&
          nxt_word[`RTC_HOUR_MSB:`RTC_SEC_LSB] == alm_tod_ff[`RTC_HOUR_MSB:`RTC_SEC_LSB])
      begin
        ev_set[`RTC_EV_ALM_TOD] = 1'b1;
      end
      if (ctrl_ff[`RTC_CTRL_ALM_DAY_EN] && nxt_word == alm_day_ff)
      begin
        ev_set[`RTC_EV_ALM_DAY] = 1'b1;
      end
    end
  end

  assign nxt_word = {nxt_day, nxt_hour, nxt_min, nxt_sec};

  // stopwatch and control; underflow stops the stopwatch by clearing its enable
  always @*
  begin
    nxt_sw = sw_ff;
    nxt_ctrl = ctrl_ff;
    if (apb_wr & wr_sw)
    begin
      nxt_sw = pwdata_in[SW_W-1:0];
    end
    else if (tick & ctrl_ff[`RTC_CTRL_SW_EN])
    begin
      if (sw_ff == {SW_W{1'b0}})
      begin
        nxt_ctrl[`RTC_CTRL_SW_EN] = 1'b0;
      end
      else
      begin
        nxt_sw = sw_ff - SW_ONE;
      end
    end
    // a control write in the same cycle overrides the hardware stop
    if (apb_wr & wr_ctrl)
    begin
      nxt_ctrl = pwdata_in[`RTC_CTRL_W-1:0];
    end
  end

  // sticky flags; a new event in the clearing cycle keeps its flag
  always @*
  begin
    ev_clr = {`RTC_EV_W{1'b0}};
    if (apb_wr & wr_stat)
    begin
      ev_clr = pwdata_in[`RTC_EV_W-1:0];
    end
    nxt_stat = (stat_ff & ~ev_clr) | ev_set;
    if (tick & ~(apb_wr & wr_sw) & ctrl_ff[`RTC_CTRL_SW_EN] & (sw_ff == {SW_W{1'b0}}))
    begin
      nxt_stat[`RTC_EV_SW] = 1'b1;
    end
  end

  // state registers
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      sec_ff <= 6'h00;
      min_ff <= 6'h00;
      hour_ff <= 5'h00;
      day_ff <= 15'h0000;
      sw_ff <= {SW_W{1'b0}};
      alm_tod_ff <= 32'h00000000;
      alm_day_ff <= 32'h00000000;
      ctrl_ff <= `RTC_CTRL_RST;
      stat_ff <= `RTC_EV_RST;
      mask_ff <= `RTC_EV_RST;
    end
    else
    begin
      sec_ff <= nxt_sec;
      min_ff <= nxt_min;
      hour_ff <= nxt_hour;
      day_ff <= nxt_day;
      sw_ff <= nxt_sw;
      ctrl_ff <= nxt_ctrl;
      stat_ff <= nxt_stat;
      if (apb_wr & wr_alm_tod)
      begin
        alm_tod_ff <= pwdata_in;
      end
      if (apb_wr & wr_alm_day)
      begin
        alm_day_ff <= pwdata_in;
      end
      if (apb_wr & wr_mask)
      begin
        mask_ff <= pwdata_in[`RTC_EV_W-1:0];
      end
    end
  end

  // apb answer: one wait state, read data captured with pready
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end
    else
    begin
      pready_out <= psel_in & penable_in & ~pready_out;
      if (psel_in & penable_in & ~pready_out)
      begin
        pslverr_out <= ~addr_ok;
        prdata_out <= pwrite_in ? 32'h00000000 : rd_mux;
      end
      else
      begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // interrupt and wake levels follow the registered flags
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      irq_out <= 1'b0;
      wake_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(stat_ff & mask_ff);
      wake_out <= ctrl_ff[`RTC_CTRL_WAKE_EN] & (|(stat_ff & mask_ff));
    end
  end

endmodule

// ==== rtc_dummy_guard.v ====
`timescale 1ns/1ps
// holds no logic; the block lives in the core, prescaler and synchroniser files

// ==== rtc_map.vh ====
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// register byte offsets
`define RTC_OFS_TIME 8'h00
`define RTC_OFS_ALM_TOD 8'h04
`define RTC_OFS_ALM_DAY 8'h08
`define RTC_OFS_SWATCH 8'h0C
`define RTC_OFS_CTRL 8'h10
`define RTC_OFS_STAT 8'h14
`define RTC_OFS_MASK 8'h18

// time word layout, shared by time and both alarm registers
`define RTC_SEC_LSB 0
`define RTC_SEC_MSB 5
`define RTC_MIN_LSB 6
`define RTC_MIN_MSB 11
`define RTC_HOUR_LSB 12
`define RTC_HOUR_MSB 16
`define RTC_DAY_LSB 17
`define RTC_DAY_MSB 31

// highest value of each counter before it wraps
`define RTC_SEC_LAST 6'h3B
`define RTC_MIN_LAST 6'h3B
`define RTC_HOUR_LAST 5'h17

// control bits
`define RTC_CTRL_RUN 0
`define RTC_CTRL_ALM_TOD_EN 1
`define RTC_CTRL_ALM_DAY_EN 2
`define RTC_CTRL_SW_EN 3
`define RTC_CTRL_WAKE_EN 4
`define RTC_CTRL_W 5
`define RTC_CTRL_RST 5'h01

// status and mask bits
`define RTC_EV_SEC 0
`define RTC_EV_MIN 1
`define RTC_EV_HOUR 2
`define RTC_EV_DAY 3
`define RTC_EV_ALM_TOD 4
`define RTC_EV_ALM_DAY 5
`define RTC_EV_SW 6
`define RTC_EV_W 7
`define RTC_EV_RST 7'h00

`endif

// ==== rtc_prescale.v ====
`timescale 1ns/1ps
// counts crystal edges and emits one tick per PRESCALE_DIV edges
module rtc_prescale
#(
  parameter PRESCALE_DIV = 32768,
  parameter CNT_W = 15
)
(
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // control
  input wire edge_in,
  input wire clear_in,
  // output
  output reg tick_out
);

  localparam integer DIV_LAST = PRESCALE_DIV - 1; // last count at full integer width
  localparam [CNT_W-1:0] CNT_LAST = DIV_LAST[CNT_W-1:0]; // last count before the tick, cut to the counter
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] cnt_ff; // crystal edges seen in this second

  // divider; clear restarts the second so a time write lands on a full second
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      cnt_ff <= {CNT_W{1'b0}};
      tick_out <= 1'b0;
    end
    else if (clear_in)
    begin
      cnt_ff <= {CNT_W{1'b0}};
      tick_out <= 1'b0;
    end
    else if (edge_in)
    begin
      if (cnt_ff == CNT_LAST)
      begin
        cnt_ff <= {CNT_W{1'b0}};
        tick_out <= 1'b1;
      end
      else
      begin
        cnt_ff <= cnt_ff + CNT_ONE;
        tick_out <= 1'b0;
      end
    end
    else
    begin
      tick_out <= 1'b0;
    end
  end

endmodule

// ==== rtc_sync.v ====
`timescale 1ns/1ps
// three-stage synchroniser with agreement filter and rising-edge pulse
module rtc_sync
(
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // asynchronous level
  input wire async_in,
  // one-cycle pulse on a filtered rising edge
  output reg rise_out
);

  reg meta_ff; // first stage, read only by the second stage
  reg sync2_ff; // second stage
  reg sync3_ff; // third stage
  reg level_ff; // filtered level, changes only when stages agree

  // shift chain; the level only moves when stage two and three agree
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      meta_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      level_ff <= 1'b0;
      rise_out <= 1'b0;
    end
    else
    begin
      meta_ff <= async_in;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff)
      begin
        level_ff <= sync3_ff;
      end
      // rising edge of the filtered level
      rise_out <= (sync2_ff == sync3_ff) & sync3_ff & ~level_ff;
    end
  end

endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
`include "rtc_map.vh"
module tb;
  // stimulus and observed ports
  reg clk_in = 0;
  reg resetn_in = 0;
  reg xtal_in = 0;
  reg psel_in = 0;
  reg penable_in = 0;
  reg pwrite_in = 0;
  reg [7:0] paddr_in = 8'h00;
  reg [31:0] pwdata_in = 32'h0;
  wire [31:0] prdata_out;
  wire pready_out;
  wire pslverr_out;
  wire irq_out;
  wire wake_out;
  integer fails = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer i;
  reg [15:0] lf = 16'hDE18;
  reg [31:0] q;
  reg e;
  reg [23:0] bads = 24'h1C02FF; // refused addresses: past the map, misaligned, far out
  // short prescale so a tick comes every few dozen bus cycles
  rtc_core #(.PRESCALE_DIV(4)) DUT (.clk_in(clk_in), .resetn_in(resetn_in), .xtal_in(xtal_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
    .wake_out(wake_out));
  initial forever #2 clk_in = ~clk_in;
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // pack a time word: day, hour, minute, second
  function [31:0] tw(input [14:0] d, input [4:0] h, input [5:0] m, input [5:0] s);
    tw = {d, h, m, s};
  endfunction
  task chk_w(input string n, input [31:0] x, input [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      fails++;
      $display("FAIL %s exp %h got %h", n, x, g);
    end
  endtask
  task chk_b(input string n, input x, input g);
    checks_done++;
    if (g !== x)
    begin
      fails++;
      $display("FAIL %s exp %b got %b", n, x, g);
    end
  endtask
  task stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    // crystal stand-in: a rising edge every 16 clocks, so a tick every 64 clocks
    xtal_in <= cyc[3];
    if (cyc == 40000)
    begin
      fails++;
      stop_test;
    end
  end
  // one apb transfer, entered just after a rising edge; answer taken at the edge that sees pready high
  task apb(input w, input [7:0] a, input [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1)
      @(posedge clk_in);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge clk_in);
  endtask
  task rd(input [7:0] a, input string n, input [31:0] x);
    apb(0, a, 32'h0);
    chk_w(n, x, q);
  endtask
  task wait_irq(input x);
    for (i = 0; i < 2000 && irq_out !== x; i++)
      @(posedge clk_in);
    chk_b("irq", x, irq_out);
  endtask
  // clear flags, unmask one source, wait for it, then read a register
  task ev_run(input [6:0] m, input [7:0] a, input [31:0] x);
    apb(1, `RTC_OFS_STAT, 32'h7F);
    apb(1, `RTC_OFS_MASK, {25'h0, m});
    wait_irq(1);
    chk_b("wake off", 1'b0, wake_out);
    rd(a, "value at event", x);
    apb(0, `RTC_OFS_STAT, 32'h0);
    chk_w("event flag", {25'h0, m}, q & {25'h0, m});
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1;
    rd(`RTC_OFS_TIME, "time", 32'h0);
    rd(`RTC_OFS_CTRL, "ctrl", 32'h1);
    rd(`RTC_OFS_STAT, "stat", 32'h0);
    rd(`RTC_OFS_MASK, "mask", 32'h0);
    // refused places: past the map and misaligned
    for (i = 0; i < 3; i++)
    begin
      apb(1, bads[8*i +: 8], 32'hFFFFFFFF);
      chk_b("wr err", 1'b1, e);
      apb(0, bads[8*i +: 8], 32'h0);
      chk_b("rd err", 1'b1, e);
      chk_w("rd data", 32'h0, q);
    end
    // random mask values, only seven bits kept
    repeat (4)
    begin
      lf = nx(lf);
      apb(1, `RTC_OFS_MASK, {16'h0, lf});
      rd(`RTC_OFS_MASK, "mask", {25'h0, lf[6:0]});
    end
    // every time counter wraps on one tick, day silently
    apb(1, `RTC_OFS_CTRL, 32'h11);
    apb(1, `RTC_OFS_STAT, 32'h7F);
    apb(1, `RTC_OFS_MASK, 32'h08);
    apb(1, `RTC_OFS_TIME, tw(15'h7FFF, 5'h17, 6'h3B, 6'h3B));
    wait_irq(1);
    chk_b("wake", 1'b1, wake_out);
    apb(1, `RTC_OFS_CTRL, 32'h10);
    rd(`RTC_OFS_TIME, "wrapped time", 32'h0);
    rd(`RTC_OFS_STAT, "tick flags", 32'h0F);
    apb(1, `RTC_OFS_MASK, 32'h0);
    wait_irq(0);
    apb(1, `RTC_OFS_MASK, 32'h08);
    wait_irq(1);
    apb(1, `RTC_OFS_STAT, 32'h0F);
    wait_irq(0);
    // alarms: day field ignored by the first, compared by the second
    apb(1, `RTC_OFS_TIME, tw(15'd5, 5'd10, 6'd20, 6'd30));
    apb(1, `RTC_OFS_ALM_TOD, tw(15'd9, 5'd10, 6'd20, 6'd32));
    apb(1, `RTC_OFS_ALM_DAY, tw(15'd5, 5'd10, 6'd20, 6'd33));
    apb(1, `RTC_OFS_CTRL, 32'h07);
    ev_run(7'h10, `RTC_OFS_TIME, tw(15'd5, 5'd10, 6'd20, 6'd32));
    ev_run(7'h20, `RTC_OFS_TIME, tw(15'd5, 5'd10, 6'd20, 6'd33));
    // stopwatch counts down to underflow and disables itself
    apb(1, `RTC_OFS_SWATCH, 32'h2);
    apb(1, `RTC_OFS_CTRL, 32'h09);
    ev_run(7'h40, `RTC_OFS_SWATCH, 32'h0);
    rd(`RTC_OFS_CTRL, "ctrl after underflow", 32'h1);
    stop_test;
  end
endmodule
